// *** sbie_core_exec.sv ***
module sbie_core_exec #(
   parameter int unsigned BANK_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fetch path
   input wire logic [15:0] instr_word,
   input wire logic [15:0] instr_next,
   output logic fetch_adv,
   output logic [15:0] ir_word,
   output logic exec_other,
   output logic nop_active,
   // addressing context
   input wire logic ext_set_en,
   input wire logic [BANK_W-1:0] bank_select_register,
   input wire logic [BANK_W+7:0] index_base,
   // data register file
   output logic [BANK_W+7:0] rf_addr,
   output logic rf_re,
   input wire logic [7:0] rf_rdata,
   output logic rf_we,
   output logic [7:0] rf_wdata,
   // working register
   output logic w_we,
   output logic [7:0] w_wdata,
   // status flags
   output logic status_we,
   output logic [sbie_pkg::FLAG_W-1:0] status_flags,
   // program counter
   output logic pc_load,
   output logic [sbie_pkg::PC_W-1:0] pc_target
);
   import sbie_pkg::*;
   localparam int unsigned ADDR_W = BANK_W + 8;

   typedef enum logic {ST_RUN, ST_NOP} sbie_state_t;

   sbie_state_t state_reg, state_next;
   logic [1:0] phase_reg;
   logic [1:0] nop_cnt_reg, nop_cnt_next;
   logic nop_branch_reg, nop_branch_next;
   logic [15:0] ir_reg;
   logic [7:0] opnd_reg;
   logic zero_reg;
   logic [ADDR_W-1:0] rf_addr_reg;
   logic rf_re_reg;
   logic rf_we_reg;
   logic [7:0] rf_wdata_reg;
   logic w_we_reg;
   logic [7:0] w_wdata_reg;
   logic status_we_reg;
   logic [FLAG_W-1:0] status_flags_reg;
   logic pc_load_reg;
   logic [PC_W-1:0] pc_target_reg;
   logic fetch_adv_reg;
   logic exec_other_reg;

   sbie_alu_if alu_bus ();
   sbie_alu u_alu (
      .bus (alu_bus)
   );

   // decode of the executing instruction
   wire run_q = (state_reg == ST_RUN);
   wire is_dec = (ir_reg[15:10] == OP_DEC_SKIP);
   wire is_inc = (ir_reg[15:10] == OP_INCR);
   wire is_br = (ir_reg[15:8] == OP_BRANCH);
   wire is_reg_op = is_dec || is_inc;
   wire to_file = ir_reg[DEST_BIT];

   // address decode straight from the fetched word so the read lands in Q2
   wire [7:0] f_fld = instr_word[7:0];
   wire a_bit = instr_word[BANK_BIT];
   wire new_reg_op = (instr_word[15:10] == OP_DEC_SKIP) || (instr_word[15:10] == OP_INCR);
   wire low_f = (f_fld <= INDEXED_MAX);
   wire use_indexed = !a_bit && ext_set_en && low_f;
   wire [ADDR_W-1:0] idx_addr = index_base + {{BANK_W{1'b0}}, f_fld};
   wire [ADDR_W-1:0] access_addr = low_f ? {{BANK_W{1'b0}}, f_fld} : {{BANK_W{1'b1}}, f_fld};
   wire [ADDR_W-1:0] bank_addr = {bank_select_register, f_fld};
   wire [ADDR_W-1:0] eff_addr = a_bit ? bank_addr : (use_indexed ? idx_addr : access_addr);

   // alu selection
   assign alu_bus.op = is_dec ? ALU_DEC : (is_inc ? ALU_INC : ALU_PASS);
   assign alu_bus.operand = opnd_reg;

   // write strobes prepared in Q3 so that they show in Q4
   wire at_q3 = (phase_reg == PH_Q3);
   wire rf_we_d = run_q && is_reg_op && to_file;
   wire w_we_d = run_q && is_reg_op && !to_file;
   wire status_we_d = run_q && is_inc;
   wire pc_load_d = run_q && is_br;
   wire fetch_adv_d = !(run_q && is_br) && !(!run_q && nop_branch_reg);
   wire exec_other_d = run_q && !is_reg_op && !is_br;
   // absolute target: no pc term enters, so any word address is reachable
   wire [PC_W-1:0] br_target = {instr_next[11:0], ir_reg[7:0], 1'b0};
   wire skip_taken = run_q && is_dec && !zero_reg;

   // sequencing at the end of Q4
   always_comb begin
      state_next = state_reg;
      nop_cnt_next = nop_cnt_reg;
      nop_branch_next = nop_branch_reg;
      if (phase_reg == PH_Q4) begin
         case (state_reg)
            ST_RUN: begin
               if (skip_taken) begin
                  state_next = ST_NOP;
                  nop_cnt_next = is_two_word(instr_next) ? NOP_TWO : NOP_ONE;
                  nop_branch_next = 1'b0;
               end else if (is_br) begin
                  state_next = ST_NOP;
                  nop_cnt_next = NOP_ONE;
                  nop_branch_next = 1'b1;
               end
            end
            ST_NOP: begin
               if (nop_cnt_reg == NOP_ONE) begin
                  state_next = ST_RUN;
                  nop_branch_next = 1'b0;
               end
               nop_cnt_next = nop_cnt_reg - NOP_ONE;
            end
            default: begin
               state_next = ST_RUN;
               nop_cnt_next = 2'h0;
               nop_branch_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_reg <= PH_RST;
         state_reg <= ST_RUN;
         nop_cnt_reg <= 2'h0;
         nop_branch_reg <= 1'b0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         state_reg <= state_next;
         nop_cnt_reg <= nop_cnt_next;
         nop_branch_reg <= nop_branch_next;
      end
   end

   // Q1 decode and Q2 read of the source byte
   always_ff @(posedge clk) begin
      if (rst) begin
         ir_reg <= IR_RST;
         rf_addr_reg <= '0;
         rf_re_reg <= 1'b0;
         opnd_reg <= 8'h00;
      end else begin
         rf_re_reg <= 1'b0;
         if (phase_reg == PH_Q1 && run_q) begin
            ir_reg <= instr_word;
            if (new_reg_op) begin
               rf_addr_reg <= eff_addr;
               rf_re_reg <= 1'b1;
            end
         end
         if (phase_reg == PH_Q2) begin
            opnd_reg <= rf_rdata;
         end
      end
   end

   // Q3 result capture; strobes are single-phase pulses in Q4
   always_ff @(posedge clk) begin
      if (rst) begin
         rf_we_reg <= 1'b0;
         w_we_reg <= 1'b0;
         status_we_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         fetch_adv_reg <= 1'b0;
         exec_other_reg <= 1'b0;
      end else begin
         rf_we_reg <= at_q3 && rf_we_d;
         w_we_reg <= at_q3 && w_we_d;
         status_we_reg <= at_q3 && status_we_d;
         pc_load_reg <= at_q3 && pc_load_d;
         fetch_adv_reg <= at_q3 && fetch_adv_d;
         exec_other_reg <= at_q3 && exec_other_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rf_wdata_reg <= 8'h00;
         w_wdata_reg <= 8'h00;
         status_flags_reg <= '0;
         pc_target_reg <= '0;
         zero_reg <= 1'b0;
      end else if (at_q3) begin
         rf_wdata_reg <= alu_bus.result;
         w_wdata_reg <= alu_bus.result;
         zero_reg <= alu_bus.zero;
         // the decrement never touches the flags: only the increment refreshes them
         if (status_we_d) begin
            status_flags_reg <= alu_bus.flags;
         end
         if (pc_load_d) begin
            pc_target_reg <= br_target;
         end
      end
   end

   // outputs
   assign fetch_adv = fetch_adv_reg;
   assign ir_word = ir_reg;
   assign exec_other = exec_other_reg;
   assign nop_active = (state_reg == ST_NOP);
   assign rf_addr = rf_addr_reg;
   assign rf_re = rf_re_reg;
   assign rf_we = rf_we_reg;
   assign rf_wdata = rf_wdata_reg;
   assign w_we = w_we_reg;
   assign w_wdata = w_wdata_reg;
   assign status_we = status_we_reg;
   assign status_flags = status_flags_reg;
   assign pc_load = pc_load_reg;
   assign pc_target = pc_target_reg;
endmodule

// *** sbie_pkg.sv ***
// Functional notes
// - opcode 0100 11da ffff ffff decrements the addressed byte, flags untouched
// - destination bit 0 writes W, 1 writes the addressed register
// - nonzero decrement result discards the fetched next instruction, one extra nop
// - skipped two-word instruction costs a second nop cycle, three in total
// - bank bit 0 uses access bank, 1 uses bank select register
// - bank bit 0 with extended set and f <= 5Fh uses indexed offset
// - decrement-skip is one word, one cycle unskipped, two when skipping a one-word instruction, three when skipping a two-word one
// - branch loads 20-bit literal into pc bits 20..1, bit 0 clear, no flags
// - branch always takes two cycles, the second a nop
// - branch reaches any word address independent of the current pc
// - increment adds one, same destination and bank bits, updates arithmetic flags
package sbie_pkg;
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   localparam logic [1:0] PH_RST = 2'h0;

   localparam logic [5:0] OP_DEC_SKIP = 6'h13;
   localparam logic [5:0] OP_INCR = 6'h0A;
   localparam logic [7:0] OP_BRANCH = 8'hEF;
   localparam logic [3:0] OP_BRANCH_W2 = 4'hF;
   localparam logic [7:0] INDEXED_MAX = 8'h5F;

   localparam int unsigned DEST_BIT = 9;
   localparam int unsigned BANK_BIT = 8;
   localparam int unsigned PC_W = 21;
   localparam int unsigned FLAG_W = 5;
   localparam int unsigned FLG_C = 0;
   localparam int unsigned FLG_DC = 1;
   localparam int unsigned FLG_Z = 2;
   localparam int unsigned FLG_OV = 3;
   localparam int unsigned FLG_N = 4;

   localparam logic [15:0] IR_RST = 16'h0000;
   localparam logic [1:0] NOP_ONE = 2'h1;
   localparam logic [1:0] NOP_TWO = 2'h2;

   typedef enum logic [1:0] {ALU_PASS, ALU_DEC, ALU_INC} sbie_alu_op_t;

   // first words of the instructions that span two program words
   function automatic logic is_two_word(input logic [15:0] w);
      is_two_word = (w[15:12] == 4'hC) || (w[15:9] == 7'h76) || (w[15:8] == 8'hEE) || (w[15:8] == 8'hEF);
   endfunction
endpackage

// *** sbie_alu_if.sv ***
interface sbie_alu_if;
   import sbie_pkg::*;
   sbie_alu_op_t op;
   logic [7:0] operand;
   logic [7:0] result;
   logic [FLAG_W-1:0] flags;
   logic zero;
   modport core (output op, output operand, input result, input flags, input zero);
   modport alu (input op, input operand, output result, output flags, output zero);
endinterface

// *** sbie_alu.sv ***
module sbie_alu (
   sbie_alu_if.alu bus
);
   import sbie_pkg::*;
   wire [7:0] addend;
   wire [8:0] sum;
   wire [4:0] low_sum;

   assign addend = (bus.op == ALU_DEC) ? 8'hFF : (bus.op == ALU_INC) ? 8'h01 : 8'h00;
   assign sum = {1'b0, bus.operand} + {1'b0, addend};
   assign low_sum = {1'b0, bus.operand[3:0]} + {1'b0, addend[3:0]};
   assign bus.result = sum[7:0];
   assign bus.zero = (sum[7:0] == 8'h00);
   assign bus.flags[FLG_C] = sum[8];
   assign bus.flags[FLG_DC] = low_sum[4];
   assign bus.flags[FLG_Z] = (sum[7:0] == 8'h00);
   // signed overflow: like-signed operands giving a differently signed result
   assign bus.flags[FLG_OV] = (bus.operand[7] == addend[7]) && (sum[7] != bus.operand[7]);
   assign bus.flags[FLG_N] = sum[7];
endmodule

// *** sbie_properties.sv ***
module sbie_exec_chk #(
   parameter int unsigned BANK_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fetch
   input wire logic [15:0] instr_next,
   input wire logic fetch_adv,
   input wire logic [15:0] ir_word,
   input wire logic exec_other,
   input wire logic nop_active,
   // addressing
   input wire logic ext_set_en,
   input wire logic [BANK_W-1:0] bank_select_register,
   input wire logic [BANK_W+7:0] index_base,
   // register file and writes
   input wire logic [BANK_W+7:0] rf_addr,
   input wire logic rf_re,
   input wire logic [7:0] rf_rdata,
   input wire logic rf_we,
   input wire logic [7:0] rf_wdata,
   input wire logic w_we,
   input wire logic [7:0] w_wdata,
   input wire logic status_we,
   input wire logic pc_load,
   input wire logic [sbie_pkg::PC_W-1:0] pc_target
);
   import sbie_pkg::*;
   logic [1:0] ph_reg;
   wire wr = rf_we | w_we;
   wire [7:0] res = rf_we ? rf_wdata : w_wdata;
   wire dec = ir_word[15:10] == OP_DEC_SKIP;
   // own phase count, so a shifted design phase shows up
   always_ff @(posedge clk) ph_reg <= rst ? 2'h0 : ph_reg + 2'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   strobe_q4_a: assert property ((wr | status_we | pc_load | exec_other) |-> ph_reg == 2'h3)
      else $error("strobe outside q4");
   read_q2_a: assert property (rf_re |-> ph_reg == 2'h1) else $error("read outside q2");
   branch_target_a: assert property (pc_load |-> ir_word[15:8] == OP_BRANCH &&
      pc_target == {instr_next[11:0], ir_word[7:0], 1'b0}) else $error("bad branch target");
   branch_nop_a: assert property (pc_load |-> !fetch_adv ##1 (nop_active && !fetch_adv) [*4] ##1 !nop_active)
      else $error("branch nop cycle wrong");
   dec_value_a: assert property (wr && dec |-> res == $past(rf_rdata, 2) - 8'h01 && !status_we)
      else $error("bad decrement");
   dest_sel_a: assert property (wr |-> rf_we == ir_word[DEST_BIT] && !(rf_we && w_we))
      else $error("bad destination");
   skip_nop_a: assert property (wr && dec && res != 8'h00 |=> nop_active [*4])
      else $error("skip missing");
   skip_long_a: assert property (wr && dec && res != 8'h00 && is_two_word(instr_next) |=> nop_active [*8])
      else $error("second skip nop missing");
   no_skip_a: assert property (wr && dec && res == 8'h00 |=> !nop_active) else $error("spurious skip");
   // the read address is formed at the q1 edge, so compare with the context of that edge
   bank_addr_a: assert property (rf_re && ir_word[BANK_BIT] |->
      rf_addr == {$past(bank_select_register), ir_word[7:0]}) else $error("bad banked address");
   index_addr_a: assert property (rf_re && !ir_word[BANK_BIT] && $past(ext_set_en) &&
      ir_word[7:0] <= INDEXED_MAX |-> rf_addr == $past(index_base) + ir_word[7:0]) else $error("bad indexed address");
   cover property (wr && dec && res != 8'h00);
   cover property (pc_load);
   cover property (rf_re && ext_set_en && !ir_word[BANK_BIT]);
endmodule
bind sbie_core_exec sbie_exec_chk #(.BANK_W(BANK_W)) i_chk (
   .clk (clk), .rst (rst), .instr_next (instr_next), .fetch_adv (fetch_adv), .ir_word (ir_word),
   .exec_other (exec_other), .nop_active (nop_active), .ext_set_en (ext_set_en),
   .bank_select_register (bank_select_register), .index_base (index_base), .rf_addr (rf_addr), .rf_re (rf_re),
   .rf_rdata (rf_rdata), .rf_we (rf_we), .rf_wdata (rf_wdata), .w_we (w_we), .w_wdata (w_wdata),
   .status_we (status_we), .pc_load (pc_load), .pc_target (pc_target)
);

// *** sbie_mem_model.sv ***
module sbie_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // program fetch
   input wire logic fetch_adv,
   input wire logic pc_load,
   input wire logic [20:0] pc_target,
   output logic [15:0] instr_word,
   output logic [15:0] instr_next,
   // data registers
   input wire logic [11:0] rf_addr,
   input wire logic rf_re,
   input wire logic rf_we,
   input wire logic [7:0] rf_wdata,
   output logic [7:0] rf_rdata
);
   logic [15:0] prog [64];
   logic [7:0] rf [4096];
   logic [5:0] pc_reg;
   assign instr_word = prog[pc_reg];
   assign instr_next = prog[pc_reg + 6'h01];
   // unread port shows the inverse, so a late sample never sees good data
   assign rf_rdata = rf_re ? rf[rf_addr] : ~rf[rf_addr];
   always @(posedge clk) begin
      if (rst) pc_reg <= 6'h00;
      else if (pc_load) pc_reg <= pc_target[6:1];
      else if (fetch_adv) pc_reg <= pc_reg + 6'h01;
      if (rf_we) rf[rf_addr] <= rf_wdata;
   end
endmodule

// *** tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbie_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ext_set_en = 1'b0;
   logic [3:0] bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h000;
   logic [15:0] instr_word, instr_next, ir_word;
   logic fetch_adv, exec_other, nop_active, rf_re, rf_we, w_we, status_we, pc_load;
   logic [11:0] rf_addr;
   logic [7:0] rf_rdata, rf_wdata, w_wdata, v1, v2, fx;
   logic [4:0] status_flags;
   logic [20:0] pc_target;
   logic [3:0] b1, b2;
   logic [19:0] k;
   logic [58:0] q [$];
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 32'hb5d7_480a;
   wire [58:0] obs = {cyc[15:0], rf_we, w_we, status_we, pc_load, exec_other, rf_we ? rf_addr : 12'h000,
      status_we ? status_flags : 5'h00, pc_load ? pc_target : {13'h0000, rf_we ? rf_wdata : w_we ? w_wdata : 8'h00}};
   always #2.5 clk = ~clk;
   sbie_core_exec i_dut (
      .clk (clk), .rst (rst), .instr_word (instr_word), .instr_next (instr_next), .fetch_adv (fetch_adv),
      .ir_word (ir_word), .exec_other (exec_other), .nop_active (nop_active), .ext_set_en (ext_set_en),
      .bank_select_register (bank_select_register), .index_base (index_base), .rf_addr (rf_addr), .rf_re (rf_re),
      .rf_rdata (rf_rdata), .rf_we (rf_we), .rf_wdata (rf_wdata), .w_we (w_we), .w_wdata (w_wdata),
      .status_we (status_we), .status_flags (status_flags), .pc_load (pc_load), .pc_target (pc_target)
   );
   sbie_mem_model i_mem (
      .clk (clk), .rst (rst), .fetch_adv (fetch_adv), .pc_load (pc_load), .pc_target (pc_target),
      .instr_word (instr_word), .instr_next (instr_next), .rf_addr (rf_addr), .rf_re (rf_re),
      .rf_we (rf_we), .rf_wdata (rf_wdata), .rf_rdata (rf_rdata)
   );
   function automatic logic [4:0] fl(input logic [7:0] v);
      logic [7:0] r;
      r = v + 8'h01;
      fl = {r[7], v == 8'h7F, r == 8'h00, v[3:0] == 4'hF, v == 8'hFF};
   endfunction
   task automatic ex(input int c, input logic [4:0] s, input logic [11:0] a, input logic [4:0] f,
         input logic [20:0] v);
      q.push_back({c[15:0], s, a, f, v});
   endtask
   task automatic chk(input logic [58:0] seen, input logic [58:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value event expected %h seen %h", exp, seen);
      end
   endtask
   task automatic conclude;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= rst ? 0 : cyc + 1;
      // an event with no note left gets a zero note, which never matches
      // strobes are unknown until the first reset edge, so nothing is taken while reset stands
      if (!rst && (rf_we | w_we | status_we | pc_load | exec_other) !== 1'b0)
         chk(obs, q.size() > 0 ? q.pop_front() : 59'h0);
   end
   always @(posedge clk) begin
      #1;
      ext_set_en = cyc >= 32;
      bank_select_register = cyc < 20 ? b1 : b2;
   end
   always @(posedge clk) if (cyc > 200) begin
      miscompares++;
      conclude();
   end
   initial begin
      logic [31:0] r;
      r = $random(seed);
      b1 = {1'b1, r[1:0], 1'b0};
      b2 = {1'b1, r[3:2], 1'b0};
      v1 = r[11:4];
      v2 = r[19:12];
      fx = {1'b1, r[26:20]};
      r = $random(seed);
      k = {r[13:0], 6'h0C};
      index_base = {2'b01, r[23:14]};
      foreach (i_mem.prog[i]) i_mem.prog[i] = 16'h0000;
      // skip single word, no skip into w, skip a two-word branch, increment, branch, indexed, increment banked
      i_mem.prog[0] = 16'h4E60;
      i_mem.prog[2] = 16'h4D20;
      i_mem.prog[3] = 16'h4E30;
      i_mem.prog[4] = 16'hEF00;
      i_mem.prog[5] = 16'hF000;
      i_mem.prog[6] = 16'h2880;
      i_mem.prog[7] = {8'hEF, k[7:0]};
      i_mem.prog[8] = {4'hF, k[19:8]};
      i_mem.prog[12] = 16'h4E05;
      i_mem.prog[13] = {8'h2B, fx};
      i_mem.rf[12'hF60] = 8'h02;
      i_mem.rf[{b1, 8'h20}] = 8'h01;
      i_mem.rf[12'h030] = 8'h00;
      i_mem.rf[12'hF80] = v1;
      i_mem.rf[index_base + 12'h005] = 8'h01;
      i_mem.rf[{b2, fx}] = v2;
      ex(3, 5'h10, 12'hF60, 5'h00, 21'h00001);
      ex(11, 5'h08, 12'h000, 5'h00, 21'h00000);
      ex(15, 5'h10, 12'h030, 5'h00, 21'h000FF);
      ex(27, 5'h0C, 12'h000, fl(v1), {13'h0000, v1 + 8'h01});
      ex(31, 5'h02, 12'h000, 5'h00, {k, 1'b0});
      ex(39, 5'h10, index_base + 12'h005, 5'h00, 21'h00000);
      ex(43, 5'h14, {b2, fx}, fl(v2), {13'h0000, v2 + 8'h01});
      ex(47, 5'h01, 12'h000, 5'h00, 21'h00000);
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      wait (cyc >= 50);
      miscompares += q.size();
      conclude();
   end
endmodule
